/* File: sbd_datapath.sv */
// Purpose: six-bit datapath registers, counters and decodes behind APB
// Assumes: single clock; subcommands issued by writing the command word
// Notes:   every APB access takes one wait state; outputs are registered
`timescale 1ns/1ps
`default_nettype none

// How it works
// - six-bit accumulator, additively modified, feeds adder
// - accumulator magnitude is its five low bits
// - eleven-bit pair is accumulator plus quotient magnitude
// - ten-bit magnitude pair drops both sign bits
// - left subcommand shifts magnitude pair one place
// - right subcommand shifts magnitude pair one place
// - two-bit adder step counter counts up
// - seven-bit countdown decrements on its subcommand
// - zero flag true exactly when countdown is zero
// - four-bit distributor counts, decodes sixteen pulses
// - sign mismatch is accumulator sign xor exchange sign
// - addition group: load, load negative, add, subtract
// - arithmetic group adds rounding, multiply, divide
// - magnitude nonzero and magnitude equals octal 37
// - six-bit instruction register holds the opcode
// - master clear zeros every datapath register; pulse line 0 and the zero flag go high
// - six external input lines load the exchange
// - six-bit quotient, five magnitude bits used
// - seven-bit memory address counter counts up
// - six-bit program address counter counts up
module sbd_datapath
    import sbd_pkg::*;
(
    // clock and reset
    input  wire logic                clk,
    input  wire logic                reset_n,
    // apb slave
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [ADDR_W-1:0]   paddr,
    input  wire logic [DATA_W-1:0]   pwdata,
    output var  logic [DATA_W-1:0]   prdata,
    output var  logic                pready,
    output var  logic                pslverr,
    // external equipment
    input  wire logic [WORD_W-1:0]   externalIn,
    // datapath views
    output var  logic [WORD_W-1:0]   accumulator,
    output var  logic [MAG_W-1:0]    accumulatorMagnitude,
    output var  logic [PAIR_W-1:0]   accumulatorQuotientPair,
    output var  logic [MPAIR_W-1:0]  magnitudePair,
    output var  logic [WORD_W-1:0]   instruction,
    // condition levels
    output var  logic                countdownZero,
    output var  logic                signMismatchLevel,
    output var  logic                additionGroupDecode,
    output var  logic                arithmeticGroupDecode,
    output var  logic                magnitudeNonZero,
    output var  logic                magnitudeAllOnes,
    // timing pulses
    output var  logic [PULSE_N-1:0]  distributorPulse
);

    // architectural state
    logic [WORD_W-1:0]  quotient;
    logic [WORD_W-1:0]  exchange;
    logic [COUNT_W-1:0] countDown;
    logic [DIST_W-1:0]  distributor;
    logic [STEP_W-1:0]  adderStepCounter;
    logic [COUNT_W-1:0] memAddress;
    logic [WORD_W-1:0]  progAddress;

    logic [WORD_W-1:0]  next_accumulator;
    logic [WORD_W-1:0]  next_quotient;
    logic [WORD_W-1:0]  next_exchange;
    logic [WORD_W-1:0]  next_instruction;
    logic [COUNT_W-1:0] next_countDown;
    logic [DIST_W-1:0]  next_distributor;
    logic [STEP_W-1:0]  next_adderStepCounter;
    logic [COUNT_W-1:0] next_memAddress;
    logic [WORD_W-1:0]  next_progAddress;

    // write strobes and subcommand pulses
    logic               busWrite;
    logic               cmdWrite;
    logic               pairShiftLeft;
    logic               pairShiftRight;
    logic               countdownStep;
    logic               systemWideReset;
    logic [MPAIR_W-1:0] pairNow;
    logic [MPAIR_W-1:0] pairShifted;

    // a write lands only on the completing edge of the access
    assign busWrite        = psel & penable & pready & pwrite;
    assign cmdWrite        = busWrite & (paddr == OFS_COMMAND);
    assign pairShiftLeft   = cmdWrite & pwdata[CMD_SHIFT_LEFT];
    assign pairShiftRight  = cmdWrite & pwdata[CMD_SHIFT_RIGHT];
    assign countdownStep   = cmdWrite & pwdata[CMD_COUNT_DOWN];
    assign systemWideReset = cmdWrite & pwdata[CMD_CLEAR_ALL];
    assign pairNow = {accumulator[MAG_W-1:0], quotient[MAG_W-1:0]};

    // one-place shift of the magnitude pair, left taking priority
    always_comb begin
        pairShifted = pairNow;
        if (pairShiftLeft) begin
            pairShifted = {pairNow[MPAIR_W-2:0], 1'b0};
        end else if (pairShiftRight) begin
            pairShifted = {1'b0, pairNow[MPAIR_W-1:1]};
        end
    end

    // datapath next state: direct writes, then subcommands, then clear
    always_comb begin
        next_accumulator      = accumulator;
        next_quotient         = quotient;
        next_exchange         = exchange;
        next_instruction      = instruction;
        next_countDown        = countDown;
        next_distributor      = distributor;
        next_adderStepCounter = adderStepCounter;
        next_memAddress       = memAddress;
        next_progAddress      = progAddress;
        if (busWrite) begin
            unique case (paddr)
                OFS_ACCUM:    next_accumulator = pwdata[WORD_W-1:0];
                OFS_QUOTIENT: next_quotient    = pwdata[WORD_W-1:0];
                OFS_EXCHANGE: next_exchange    = pwdata[WORD_W-1:0];
                OFS_INSTR:    next_instruction = pwdata[WORD_W-1:0];
                OFS_COUNTDN:  next_countDown   = pwdata[COUNT_W-1:0];
                OFS_DISTRIB:  next_distributor = pwdata[DIST_W-1:0];
                OFS_ADDSTEP:  next_adderStepCounter = pwdata[STEP_W-1:0];
                OFS_MEMADDR:  next_memAddress  = pwdata[COUNT_W-1:0];
                OFS_PROGADDR: next_progAddress = pwdata[WORD_W-1:0];
                default: ;
            endcase
        end
        if (cmdWrite) begin
            // add the exchange into the accumulator, wrapping at six bits
            if (pwdata[CMD_ADD]) begin
                next_accumulator = accumulator + exchange;
            end
            if (pairShiftLeft || pairShiftRight) begin
                // signs stay, magnitudes move as one ten-bit word
                next_accumulator = {accumulator[SIGN_BIT],
                                    pairShifted[MPAIR_W-1:MAG_W]};
                next_quotient    = {quotient[SIGN_BIT],
                                    pairShifted[MAG_W-1:0]};
            end
            if (countdownStep) begin
                next_countDown = countDown - 7'h01;
            end
            if (pwdata[CMD_STEP_ADDER]) begin
                next_adderStepCounter = adderStepCounter + 2'h1;
            end
            if (pwdata[CMD_STEP_DIST]) begin
                next_distributor = distributor + 4'h1;
            end
            if (pwdata[CMD_INC_MEM]) begin
                next_memAddress = memAddress + 7'h01;
            end
            if (pwdata[CMD_INC_PROG]) begin
                next_progAddress = progAddress + 6'h01;
            end
            if (pwdata[CMD_LOAD_EXT]) begin
                next_exchange = externalIn;
            end
        end
        // master clear overrides every other change
        if (systemWideReset) begin
            next_accumulator      = RST_WORD;
            next_quotient         = RST_WORD;
            next_exchange         = RST_WORD;
            next_instruction      = RST_WORD;
            next_countDown        = RST_COUNT;
            next_distributor      = RST_DIST;
            next_adderStepCounter = RST_STEP;
            next_memAddress       = RST_COUNT;
            next_progAddress      = RST_WORD;
        end
    end

    // derived levels are computed from next state so they match the regs
    logic [MAG_W-1:0]   next_accumulatorMagnitude;
    logic [PAIR_W-1:0]  next_accumulatorQuotientPair;
    logic [MPAIR_W-1:0] next_magnitudePair;
    logic               next_countdownZero;
    logic               next_signMismatchLevel;
    logic               next_additionGroupDecode;
    logic               next_arithmeticGroupDecode;
    logic               next_magnitudeNonZero;
    logic               next_magnitudeAllOnes;
    logic [WORD_W-2:0]  opHigh;

    // odd/even opcode pairs share a decode, so bit 0 is ignored
    always_comb begin
        opHigh = next_instruction[WORD_W-1:1];
        next_accumulatorMagnitude = next_accumulator[MAG_W-1:0];
        next_accumulatorQuotientPair = {next_accumulator,
                                        next_quotient[MAG_W-1:0]};
        next_magnitudePair = {next_accumulator[MAG_W-1:0],
                              next_quotient[MAG_W-1:0]};
        next_countdownZero = (next_countDown == RST_COUNT);
        next_signMismatchLevel = next_accumulator[SIGN_BIT]
                               ^ next_exchange[SIGN_BIT];
        next_additionGroupDecode = (opHigh == OP_LOAD[WORD_W-1:1])
                                 | (opHigh == OP_LOAD_NEG[WORD_W-1:1])
                                 | (opHigh == OP_ADD[WORD_W-1:1])
                                 | (opHigh == OP_SUB[WORD_W-1:1]);
        next_arithmeticGroupDecode = next_additionGroupDecode
                                 | (opHigh == OP_RND_ADD[WORD_W-1:1])
                                 | (opHigh == OP_RND_SUB[WORD_W-1:1])
                                 | (opHigh == OP_MULTIPLY[WORD_W-1:1])
                                 | (opHigh == OP_DIVIDE[WORD_W-1:1]);
        next_magnitudeNonZero = |next_accumulator[MAG_W-1:0];
        next_magnitudeAllOnes = (next_accumulator[MAG_W-1:0] == MAG_FULL);
    end

    // all datapath state on the one equipment clock
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            accumulator             <= RST_WORD;
            quotient                <= RST_WORD;
            exchange                <= RST_WORD;
            instruction             <= RST_WORD;
            countDown               <= RST_COUNT;
            distributor             <= RST_DIST;
            adderStepCounter        <= RST_STEP;
            memAddress              <= RST_COUNT;
            progAddress             <= RST_WORD;
            accumulatorMagnitude    <= '0;
            accumulatorQuotientPair <= '0;
            magnitudePair           <= '0;
            countdownZero           <= 1'b1;
            signMismatchLevel       <= 1'b0;
            additionGroupDecode     <= 1'b0;
            arithmeticGroupDecode   <= 1'b0;
            magnitudeNonZero        <= 1'b0;
            magnitudeAllOnes        <= 1'b0;
        end else begin
            accumulator             <= next_accumulator;
            quotient                <= next_quotient;
            exchange                <= next_exchange;
            instruction             <= next_instruction;
            countDown               <= next_countDown;
            distributor             <= next_distributor;
            adderStepCounter        <= next_adderStepCounter;
            memAddress              <= next_memAddress;
            progAddress             <= next_progAddress;
            accumulatorMagnitude    <= next_accumulatorMagnitude;
            accumulatorQuotientPair <= next_accumulatorQuotientPair;
            magnitudePair           <= next_magnitudePair;
            countdownZero           <= next_countdownZero;
            signMismatchLevel       <= next_signMismatchLevel;
            additionGroupDecode     <= next_additionGroupDecode;
            arithmeticGroupDecode   <= next_arithmeticGroupDecode;
            magnitudeNonZero        <= next_magnitudeNonZero;
            magnitudeAllOnes        <= next_magnitudeAllOnes;
        end
    end

    // pulse decode fed with the next count keeps it aligned to the reg
    sbd_pulse_decode u_pulse (
        .clk              (clk),
        .reset_n          (reset_n),
        .nextCount        (next_distributor),
        .distributorPulse (distributorPulse)
    );

    // apb answer: one wait state gives read data time to settle
    logic [DATA_W-1:0] next_prdata;
    logic              next_pready;
    logic              next_pslverr;
    logic [DATA_W-1:0] readWord;
    logic              mapped;

    always_comb begin
        readWord = RST_DATA;
        mapped   = 1'b1;
        unique case (paddr)
            OFS_ACCUM:    readWord[WORD_W-1:0]  = accumulator;
            OFS_QUOTIENT: readWord[WORD_W-1:0]  = quotient;
            OFS_EXCHANGE: readWord[WORD_W-1:0]  = exchange;
            OFS_INSTR:    readWord[WORD_W-1:0]  = instruction;
            OFS_COUNTDN:  readWord[COUNT_W-1:0] = countDown;
            OFS_DISTRIB:  readWord[DIST_W-1:0]  = distributor;
            OFS_ADDSTEP:  readWord[STEP_W-1:0]  = adderStepCounter;
            OFS_MEMADDR:  readWord[COUNT_W-1:0] = memAddress;
            OFS_PROGADDR: readWord[WORD_W-1:0]  = progAddress;
            OFS_COMMAND:  readWord = RST_DATA; // commands read as zero
            OFS_STATUS: begin
                readWord[ST_COUNT_ZERO]  = countdownZero;
                readWord[ST_SIGN_DIFF]   = signMismatchLevel;
                readWord[ST_ADD_GROUP]   = additionGroupDecode;
                readWord[ST_ARITH_GROUP] = arithmeticGroupDecode;
                readWord[ST_MAG_NONZERO] = magnitudeNonZero;
                readWord[ST_MAG_ALLONES] = magnitudeAllOnes;
                readWord[ST_MAG_LSB +: MAG_W] = accumulatorMagnitude;
            end
            OFS_PAIR:     readWord[PAIR_W-1:0]  = accumulatorQuotientPair;
            OFS_MAGPAIR:  readWord[MPAIR_W-1:0] = magnitudePair;
            OFS_EXTIN:    readWord[WORD_W-1:0]  = externalIn;
            default:      mapped = 1'b0;
        endcase
        next_pready  = psel & penable & ~pready;
        next_pslverr = next_pready & ~mapped;
        next_prdata  = (next_pready & ~pwrite) ? readWord : RST_DATA;
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= RST_DATA;
        end else begin
            pready  <= next_pready;
            pslverr <= next_pslverr;
            prdata  <= next_prdata;
        end
    end

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    sequence accessWait;
        psel && penable && !pready;
    endsequence
    sequence accessDone;
        pready ##1 !pready;
    endsequence

    logic [MPAIR_W-1:0] pairLeft;
    logic [MPAIR_W-1:0] pairRight;
    assign pairLeft  = {pairNow[MPAIR_W-2:0], 1'b0};
    assign pairRight = {1'b0, pairNow[MPAIR_W-1:1]};

    chk_apb_wait_state: assert property (
        accessWait |=> accessDone)
        else $error("apb answer not after one wait state");
    chk_shift_left_pair: assert property (
        pairShiftLeft && !systemWideReset
        |=> magnitudePair == $past(pairLeft))
        else $error("left shift of magnitude pair wrong");
    chk_shift_right_pair: assert property (
        pairShiftRight && !pairShiftLeft && !systemWideReset
        |=> magnitudePair == $past(pairRight) && !magnitudePair[MPAIR_W-1])
        else $error("right shift of magnitude pair wrong");
    chk_countdown_step: assert property (
        countdownStep && !systemWideReset
        |=> countDown == $past(countDown) - 7'h01)
        else $error("countdown did not step by one");
    chk_zero_flag: assert property (
        countdownZero == (countDown == RST_COUNT))
        else $error("countdown zero flag mismatch");
    chk_dist_pulse_onehot: assert property (
        distributorPulse == (16'h0001 << distributor))
        else $error("distributor pulse not matching count");
    chk_sign_mismatch: assert property (
        signMismatchLevel == (accumulator[SIGN_BIT] ^ exchange[SIGN_BIT]))
        else $error("sign mismatch level wrong");
    chk_group_nesting: assert property (
        additionGroupDecode |-> arithmeticGroupDecode)
        else $error("addition group outside arithmetic group");
    chk_mag_tests: assert property (
        magnitudeAllOnes |-> magnitudeNonZero
        && accumulator[MAG_W-1:0] == MAG_FULL)
        else $error("magnitude tests inconsistent");
    chk_master_clear: assert property (
        systemWideReset |=> accumulator == RST_WORD && quotient == RST_WORD
        && countDown == RST_COUNT && distributorPulse == 16'h0001)
        else $error("master clear left state behind");

endmodule
`default_nettype wire

/* File: sbd_pkg.sv */
// Purpose: shared constants for the six-bit datapath register block
// Assumes: 32-bit APB, byte addresses, one register per aligned word
// Notes:   opcodes decode on the upper five bits (odd/even pairs)
package sbd_pkg;

    // widths of the datapath registers
    localparam int WORD_W    = 6;
    localparam int MAG_W     = 5;
    localparam int COUNT_W   = 7;
    localparam int DIST_W    = 4;
    localparam int STEP_W    = 2;
    localparam int PAIR_W    = 11;
    localparam int MPAIR_W   = 10;
    localparam int PULSE_N   = 16;
    localparam int ADDR_W    = 8;
    localparam int DATA_W    = 32;

    // register byte offsets
    localparam logic [ADDR_W-1:0] OFS_ACCUM    = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_QUOTIENT = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_EXCHANGE = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_INSTR    = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_COUNTDN  = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_DISTRIB  = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_ADDSTEP  = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_MEMADDR  = 8'h1C;
    localparam logic [ADDR_W-1:0] OFS_PROGADDR = 8'h20;
    localparam logic [ADDR_W-1:0] OFS_COMMAND  = 8'h24;
    localparam logic [ADDR_W-1:0] OFS_STATUS   = 8'h28;
    localparam logic [ADDR_W-1:0] OFS_PAIR     = 8'h2C;
    localparam logic [ADDR_W-1:0] OFS_MAGPAIR  = 8'h30;
    localparam logic [ADDR_W-1:0] OFS_EXTIN    = 8'h34;

    // command register bits, each a one-shot subcommand
    localparam int CMD_SHIFT_LEFT  = 0;
    localparam int CMD_SHIFT_RIGHT = 1;
    localparam int CMD_COUNT_DOWN  = 2;
    localparam int CMD_STEP_ADDER  = 3;
    localparam int CMD_STEP_DIST   = 4;
    localparam int CMD_INC_MEM     = 5;
    localparam int CMD_INC_PROG    = 6;
    localparam int CMD_ADD         = 7;
    localparam int CMD_LOAD_EXT    = 8;
    localparam int CMD_CLEAR_ALL   = 9;

    // status register bits
    localparam int ST_COUNT_ZERO   = 0;
    localparam int ST_SIGN_DIFF    = 1;
    localparam int ST_ADD_GROUP    = 2;
    localparam int ST_ARITH_GROUP  = 3;
    localparam int ST_MAG_NONZERO  = 4;
    localparam int ST_MAG_ALLONES  = 5;
    localparam int ST_MAG_LSB      = 8;

    // sign sits in the leftmost bit
    localparam int SIGN_BIT = 5;

    // opcodes of the arithmetic instructions
    localparam logic [WORD_W-1:0] OP_LOAD     = 6'h20;
    localparam logic [WORD_W-1:0] OP_LOAD_NEG = 6'h22;
    localparam logic [WORD_W-1:0] OP_ADD      = 6'h24;
    localparam logic [WORD_W-1:0] OP_SUB      = 6'h26;
    localparam logic [WORD_W-1:0] OP_RND_ADD  = 6'h28;
    localparam logic [WORD_W-1:0] OP_RND_SUB  = 6'h2A;
    localparam logic [WORD_W-1:0] OP_MULTIPLY = 6'h2C;
    localparam logic [WORD_W-1:0] OP_DIVIDE   = 6'h2E;

    // magnitude test value, octal 37
    localparam logic [MAG_W-1:0] MAG_FULL = 5'h1F;

    // reset values
    localparam logic [WORD_W-1:0]  RST_WORD  = 6'h00;
    localparam logic [COUNT_W-1:0] RST_COUNT = 7'h00;
    localparam logic [DIST_W-1:0]  RST_DIST  = 4'h0;
    localparam logic [STEP_W-1:0]  RST_STEP  = 2'h0;
    localparam logic [DATA_W-1:0]  RST_DATA  = 32'h0000_0000;

endpackage

/* File: sbd_pulse_decode.sv */
// Purpose: registered one-of-sixteen decode of the distributor count
// Assumes: fed with the next distributor value so pulse tracks the count
// Notes:   clear sets pulse line 0 and zeros the other fifteen, with the rest of the system
`timescale 1ns/1ps
`default_nettype none
module sbd_pulse_decode
    import sbd_pkg::*;
(
    // clock and reset
    input  wire logic               clk,
    input  wire logic               reset_n,
    // count in, pulses out
    input  wire logic [DIST_W-1:0]  nextCount,
    output var  logic [PULSE_N-1:0] distributorPulse
);

    // after a clear the count is zero, so its pulse line must stand high
    localparam logic [PULSE_N-1:0] RST_PULSE = PULSE_N'(1) << RST_DIST;

    logic [PULSE_N-1:0] next_distributorPulse;

    // one comparator per pulse line
    for (genvar i = 0; i < PULSE_N; i++) begin : g_line
        assign next_distributorPulse[i] = (nextCount == DIST_W'(i));
    end

    // register the decode so the pulse is glitch free
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            distributorPulse <= RST_PULSE;
        end else begin
            distributorPulse <= next_distributorPulse;
        end
    end

endmodule
`default_nettype wire

/* File: test_sbd_datapath.sv */
// Purpose: self-checking bench for the six-bit datapath register block
// Assumes: APB slave answers with pready; bench waits for it, bounded
// Notes:   operands drawn from a fixed seed, corner values mixed in
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
    err_total++; $display("MISMATCH %s exp %h got %h", n, e, g); end end
module test_sbd_datapath
    import sbd_pkg::*;
;
    logic clk, reset_n, psel, penable, pwrite, pready, pslverr;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata, prdata, r;
    logic [WORD_W-1:0] externalIn, accumulator, instruction, a, q, x;
    logic [MAG_W-1:0] accumulatorMagnitude;
    logic [PAIR_W-1:0] accumulatorQuotientPair;
    logic [MPAIR_W-1:0] magnitudePair, m;
    logic countdownZero, signMismatchLevel, additionGroupDecode;
    logic arithmeticGroupDecode, magnitudeNonZero, magnitudeAllOnes, e;
    logic [PULSE_N-1:0] distributorPulse;
    int err_total = 0;
    int check_count = 0;

    sbd_datapath uut (.*);

    // free-running 250 MHz clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // one-place shift of the magnitude pair, zero fill
    function automatic logic [9:0] shf(input logic [9:0] v, input logic lf);
        return lf ? {v[8:0], 1'b0} : {1'b0, v[9:1]};
    endfunction

    // one transfer; checks happen at the following falling edge
    task automatic apb(input logic w, input logic [7:0] ad, input int d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // wait for the answer; only the watchdog ends a hang
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(negedge clk);
    endtask

    task automatic cmd(input int b);
        apb(1'b1, OFS_COMMAND, 1 << b);
    endtask

    task automatic report_and_stop;
        if (err_total == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // watchdog far beyond the expected run length
    initial begin
        #40000;
        err_total++;
        report_and_stop();
    end

    initial begin
        {reset_n, psel, penable, pwrite, paddr, pwdata} = '0;
        externalIn = 6'h15;
        void'($urandom(32'h50b78736));
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        @(negedge clk);
        `CHK("czero", 1'b1, countdownZero)
        `CHK("pulse", 16'h0001, distributorPulse)
        for (int i = 0; i < 20; i++) begin
            a = (i == 0) ? 6'h1F : (i == 1) ? 6'h20 : 6'($urandom);
            q = 6'($urandom);
            x = 6'($urandom);
            apb(1'b1, OFS_ACCUM, a);
            apb(1'b1, OFS_QUOTIENT, q);
            apb(1'b1, OFS_EXCHANGE, x);
            `CHK("acc", a, accumulator)
            `CHK("amag", a[4:0], accumulatorMagnitude)
            `CHK("pair", {a, q[4:0]}, accumulatorQuotientPair)
            `CHK("mpair", {a[4:0], q[4:0]}, magnitudePair)
            `CHK("xor", a[5] ^ x[5], signMismatchLevel)
            `CHK("nz", a[4:0] != 0, magnitudeNonZero)
            `CHK("ones", a[4:0] == MAG_FULL, magnitudeAllOnes)
            m = shf({a[4:0], q[4:0]}, i[0]);
            cmd(i[0] ? CMD_SHIFT_LEFT : CMD_SHIFT_RIGHT);
            `CHK("shift", m, magnitudePair)
            cmd(CMD_ADD);
            `CHK("add", 6'({a[5], m[9:5]} + x), accumulator)
        end
        apb(1'b1, OFS_COUNTDN, 1);
        cmd(CMD_COUNT_DOWN);
        `CHK("czero", 1'b1, countdownZero)
        cmd(CMD_COUNT_DOWN);
        apb(1'b0, OFS_COUNTDN, 0);
        `CHK("cdown", 32'h7F, r)
        for (int k = 1; k <= 16; k++) begin
            cmd(CMD_STEP_DIST);
            `CHK("dist", 16'(1 << (k % 16)), distributorPulse)
        end
        repeat (5) cmd(CMD_STEP_ADDER);
        apb(1'b0, OFS_ADDSTEP, 0);
        `CHK("astep", 32'h1, r)
        apb(1'b1, OFS_MEMADDR, 32'h7F);
        cmd(CMD_INC_MEM);
        apb(1'b0, OFS_MEMADDR, 0);
        `CHK("maddr", 32'h0, r)
        apb(1'b1, OFS_PROGADDR, 32'h3E);
        cmd(CMD_INC_PROG);
        apb(1'b0, OFS_PROGADDR, 0);
        `CHK("paddr", 32'h3F, r)
        for (int o = 0; o < 64; o++) begin
            apb(1'b1, OFS_INSTR, o);
            `CHK("instr", 6'(o), instruction)
            `CHK("addg", o[5:3] == 3'b100, additionGroupDecode)
            `CHK("arig", o[5:4] == 2'b10, arithmeticGroupDecode)
        end
        @(posedge clk);
        externalIn <= 6'($urandom);
        cmd(CMD_LOAD_EXT);
        apb(1'b0, OFS_EXCHANGE, 0);
        `CHK("ext", {26'h0, externalIn}, r)
        apb(1'b0, 8'h40, 0);
        `CHK("err", 1'b1, e)
        // move the distributor off zero so the clear has work to do
        cmd(CMD_STEP_DIST);
        cmd(CMD_CLEAR_ALL);
        `CHK("clr", 6'h00, accumulator)
        `CHK("clrc", 1'b1, countdownZero)
        `CHK("clrd", 16'h0001, distributorPulse)
        report_and_stop();
    end
endmodule
`default_nettype wire
